/* File: design/tdm_clk_pkg.sv */
// Package: register map, fields and constants of the bus clock controller
package tdm_clk_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CLK_MODE = 8'h00;
   localparam logic [7:0] ADDR_TERM = 8'h04;
   localparam logic [7:0] ADDR_ERR = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_SPAN_TE = 8'h10;
   localparam logic [7:0] ADDR_STREAM_MAP = 8'h14;
   // set_clock_command field positions
   localparam int MODE_LSB = 0;
   localparam int SUB_LSB = 4;
   localparam int ARGA_LSB = 8;
   localparam int ARGBB_LSB = 16;
   localparam int ARGC_LSB = 24;
   // Stream map field positions
   localparam int SMAP_STREAM_LSB = 0;
   localparam int SMAP_TS_LSB = 8;
   // Clock modes
   localparam logic [2:0] MODE_NONE = 3'h0;
   localparam logic [2:0] MODE_SLAVE = 3'h1;
   localparam logic [2:0] MODE_PRI_A = 3'h2;
   localparam logic [2:0] MODE_PRI_B = 3'h3;
   localparam logic [2:0] MODE_SEC_A = 3'h4;
   localparam logic [2:0] MODE_SEC_B = 3'h5;
   // Limits
   localparam logic [2:0] SLAVE_ARGA_MAX = 3'h1;
   localparam logic [2:0] MASTER_SUB_MAX = 3'h4;
   localparam logic [2:0] MASTER_ARGA_MAX = 3'h5;
   localparam logic [7:0] NETREF_FREQ_8K = 8'h00;
   localparam logic [4:0] LEGACY_STREAM_MAX = 5'h0f;
   localparam logic [6:0] TS_MAX_4M = 7'h3f;
   // Error bitmap positions
   localparam int ERR_BUS_A = 0;
   localparam int ERR_BUS_B = 1;
   localparam int ERR_SC = 2;
   localparam int ERR_MVIP = 3;
   localparam int ERR_PLL = 4;
   localparam int ERR_COMPAT = 5;
   localparam int ERR_FAILSAFE = 6;
   // Reset values
   localparam logic [1:0] TERM_RESET = 2'h0;
   localparam logic [7:0] SPAN_TE_RESET = 8'h00;
   // Supervision window
   localparam int CLK_PERIOD_PS = 4000;
   localparam int LOSS_WINDOW_NS = 500;
   localparam int LOSS_WINDOW_CYC = (LOSS_WINDOW_NS * 1000) / CLK_PERIOD_PS;
   // Monitored clock inputs
   localparam int NUM_MON = 4;
   localparam int MON_A = 0;
   localparam int MON_B = 1;
   localparam int MON_SC = 2;
   localparam int MON_MVIP = 3;
   typedef enum logic [3:0] {
      REF_LOCAL, REF_BUS_A, REF_BUS_B, REF_SC2, REF_SC4, REF_SC8,
      REF_MVIP, REF_NETREF1, REF_NETREF2, REF_SPAN, REF_HOLDOVER
   } ref_t;
endpackage

/* File: design/clk_loss_mon.sv */
// Loss-of-clock supervisor for one externally sourced clock
`timescale 1ns/10ps
module clk_loss_mon #(
   parameter int WINDOW = 125
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Monitored clock line
   input wire logic mon_clk,
   // Loss indication
   output logic lost
);
   localparam int CW = $clog2(WINDOW + 1);
   logic sync1_q;
   logic sync2_q;
   logic last_q;
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         sync1_q <= mon_clk;
         sync2_q <= sync1_q;
         last_q <= sync2_q;
      end
   end

   // Any edge restarts the window; the window holds at its end
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (sync2_q != last_q) begin
         cnt_q <= '0;
      end else if (cnt_q != CW'(WINDOW)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lost <= 1'b0;
      end else begin
         lost <= (cnt_q == CW'(WINDOW));
      end
   end
endmodule

/* File: design/tdm_clk_ctrl.sv */
// Backplane bus clock mode controller with APB register access
//
// Functional notes
// - Even streams to legacy outputs, odd to inputs
// - At 4 MHz, timeslots 00-3F only
// - Legacy streams numbered 00 to 0F
// - Set-clock carries mode, sub, a, bb, c
// - After reset, local clock, no bus clocking
// - Modes: none, slave, primary A/B, secondary A/B
// - Slave sub-mode picks reference, 6/7 fallback
// - Slave drives netref only when a is 1
// - Slave netref span must be customer interface; here it must be terminal (span_te_q bit set), as for masters
// - Primary drives own clock from chosen source
// - Master sub 1/2 accepts only 8 kHz
// - Master sub 3/4 span must be terminal
// - Masters generate legacy clocks chosen by a
// - Secondary locks to opposite, drives its own
// - On loss secondary switches to sub source
// - Secondary takes over as primary on loss
// - Secondary arguments read as primary arguments; here sub 0 takes holdover, not local
// - Auto-fallback switches clock and reports error
// - Error bitmap: A, B, legacy, PLL, 1, failsafe
// - Separate terminations, both disabled at reset
`timescale 1ns/10ps
module tdm_clk_ctrl
   import tdm_clk_pkg::*;
#(
   parameter int NUM_SPANS = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Backplane clock A and B pins
   input wire logic bus_clk_a_i,
   output logic bus_clk_a_o,
   output logic bus_clk_a_oe,
   input wire logic bus_clk_b_i,
   output logic bus_clk_b_o,
   output logic bus_clk_b_oe,
   // Legacy clock inputs
   input wire logic legacy_sc_clk_i,
   input wire logic legacy_mvip_clk_i,
   // Local PLL
   input wire logic pll_clk_i,
   input wire logic pll_locked_i,
   output ref_t ref_sel,
   output logic [7:0] ref_span,
   // Network reference and legacy generation
   output logic netref_oe,
   output logic [7:0] netref_span,
   output logic [3:0] netref_freq,
   output logic [2:0] legacy_gen_sel,
   // Span loss of signal from framers
   input wire logic [NUM_SPANS-1:0] span_los_i,
   // Terminations
   output logic bus_term_en,
   output logic legacy_term_en,
   // Clock error report
   output logic err_report_valid,
   output logic [6:0] err_report_data
);
   // ------------------------------------------------------------
   // Input synchronisers and clock supervision
   // ------------------------------------------------------------
   logic [NUM_MON-1:0] mon_in;
   logic [NUM_MON-1:0] lost;
   logic [NUM_SPANS+1:0] async1_q;
   logic [NUM_SPANS+1:0] async2_q;
   logic pll_locked;
   logic pll_clk_s;
   logic [NUM_SPANS-1:0] span_los;

   assign mon_in = {legacy_mvip_clk_i, legacy_sc_clk_i,
                    bus_clk_b_i, bus_clk_a_i};

   generate
      for (genvar i = 0; i < NUM_MON; i++) begin : g_mon
         clk_loss_mon #(.WINDOW(LOSS_WINDOW_CYC)) u_mon (
            .clk(clk),
            .reset(reset),
            .mon_clk(mon_in[i]),
            .lost(lost[i])
         );
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         async1_q <= '0;
         async2_q <= '0;
      end else begin
         async1_q <= {pll_clk_i, pll_locked_i, span_los_i};
         async2_q <= async1_q;
      end
   end
   assign span_los = async2_q[NUM_SPANS-1:0];
   assign pll_locked = async2_q[NUM_SPANS];
   assign pll_clk_s = async2_q[NUM_SPANS+1];

   // ------------------------------------------------------------
   // Command checking
   // ------------------------------------------------------------
   function automatic logic span_ok(input logic [7:0] idx,
                                    input logic [7:0] te);
      span_ok = (idx < 8'(NUM_SPANS)) && te[idx[2:0]];
   endfunction

   function automatic logic cmd_ok(input logic [31:0] c,
                                   input logic [7:0] te);
      logic [2:0] m;
      logic [2:0] s;
      logic [2:0] a;
      logic [7:0] bb;
      m = c[MODE_LSB +: 3];
      s = c[SUB_LSB +: 3];
      a = c[ARGA_LSB +: 3];
      bb = c[ARGBB_LSB +: 8];
      cmd_ok = 1'b1;
      if (m > MODE_SEC_B) begin
         cmd_ok = 1'b0;
      end else if (m == MODE_SLAVE) begin
         if (a > SLAVE_ARGA_MAX) begin
            cmd_ok = 1'b0;
         end else if (a[0] && !span_ok(bb, te)) begin
            cmd_ok = 1'b0;
         end
      end else if (m != MODE_NONE) begin
         // Secondary modes share primary argument checks
         if (s > MASTER_SUB_MAX || a > MASTER_ARGA_MAX) begin
            cmd_ok = 1'b0;
         end else if ((s == 3'h1 || s == 3'h2) &&
                      bb != NETREF_FREQ_8K) begin
            cmd_ok = 1'b0;
         end else if ((s == 3'h3 || s == 3'h4) &&
                      !span_ok(bb, te)) begin
            cmd_ok = 1'b0;
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic wr_en;
   logic [2:0] mode_q;
   logic [2:0] sub_q;
   logic [2:0] arga_q;
   logic [7:0] argbb_q;
   logic [3:0] argc_q;
   logic cmd_err_q;
   logic [1:0] term_q;
   logic [7:0] span_te_q;
   logic [4:0] smap_stream_q;
   logic [6:0] smap_ts_q;
   logic clk_cmd_wr;

   assign wr_en = psel && penable && pwrite;
   assign clk_cmd_wr = wr_en && paddr == ADDR_CLK_MODE;

   // A rejected command leaves mode and arguments untouched but clears fallback and takeover state
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_q <= MODE_NONE;
         sub_q <= '0;
         arga_q <= '0;
         argbb_q <= '0;
         argc_q <= '0;
         cmd_err_q <= 1'b0;
      end else if (clk_cmd_wr) begin
         if (cmd_ok(pwdata, span_te_q)) begin
            mode_q <= pwdata[MODE_LSB +: 3];
            sub_q <= pwdata[SUB_LSB +: 3];
            arga_q <= pwdata[ARGA_LSB +: 3];
            argbb_q <= pwdata[ARGBB_LSB +: 8];
            argc_q <= pwdata[ARGC_LSB +: 4];
            cmd_err_q <= 1'b0;
         end else begin
            cmd_err_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         term_q <= TERM_RESET;
         span_te_q <= SPAN_TE_RESET;
         smap_stream_q <= '0;
         smap_ts_q <= '0;
      end else if (wr_en) begin
         if (paddr == ADDR_TERM) begin
            term_q <= pwdata[1:0];
         end
         if (paddr == ADDR_SPAN_TE) begin
            span_te_q <= pwdata[7:0];
         end
         if (paddr == ADDR_STREAM_MAP) begin
            smap_stream_q <= pwdata[SMAP_STREAM_LSB +: 5];
            smap_ts_q <= pwdata[SMAP_TS_LSB +: 7];
         end
      end
   end
   assign bus_term_en = term_q[0];
   assign legacy_term_en = term_q[1];

   // ------------------------------------------------------------
   // Fallback and takeover supervision
   // ------------------------------------------------------------
   logic is_slave;
   logic is_pri;
   logic is_sec;
   logic own_b;
   logic fb_q;
   logic take_q;
   logic span_fb_q;
   logic slave_watch_lost;
   logic sec_watch_lost;

   assign is_slave = mode_q == MODE_SLAVE;
   assign is_pri = mode_q == MODE_PRI_A || mode_q == MODE_PRI_B;
   assign is_sec = mode_q == MODE_SEC_A || mode_q == MODE_SEC_B;
   // Clock B is driven in modes 3 and 5
   assign own_b = mode_q[0];
   assign slave_watch_lost = sub_q == 3'h6 ? lost[MON_A] : lost[MON_B];
   assign sec_watch_lost = own_b ? lost[MON_A] : lost[MON_B];

   // Only a fresh clock command returns the block to its first source
   always_ff @(posedge clk) begin
      if (reset || clk_cmd_wr) begin
         fb_q <= 1'b0;
         take_q <= 1'b0;
         span_fb_q <= 1'b0;
      end else begin
         if (is_slave && sub_q[2:1] == 2'b11 && slave_watch_lost) begin
            fb_q <= 1'b1;
         end
         if (is_sec && sec_watch_lost) begin
            take_q <= 1'b1;
         end
         if ((is_pri || take_q) && sub_q == 3'h4 &&
             span_los[argbb_q[2:0]]) begin
            span_fb_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Reference and drive selection
   // ------------------------------------------------------------
   ref_t master_ref;
   ref_t ref_d;

   always_comb begin
      case (sub_q)
         3'h0: master_ref = is_sec ? REF_HOLDOVER : REF_LOCAL;
         3'h1: master_ref = REF_NETREF1;
         3'h2: master_ref = REF_NETREF2;
         3'h3: master_ref = REF_SPAN;
         3'h4: master_ref = span_fb_q ? REF_NETREF1 : REF_SPAN;
         default: master_ref = REF_LOCAL;
      endcase
   end

   always_comb begin
      case (mode_q)
         MODE_SLAVE: begin
            case (sub_q)
               3'h0: ref_d = REF_BUS_A;
               3'h1: ref_d = REF_BUS_B;
               3'h2: ref_d = REF_SC2;
               3'h3: ref_d = REF_SC4;
               3'h4: ref_d = REF_SC8;
               3'h5: ref_d = REF_MVIP;
               3'h6: ref_d = fb_q ? REF_BUS_B : REF_BUS_A;
               default: ref_d = fb_q ? REF_BUS_A : REF_BUS_B;
            endcase
         end
         MODE_PRI_A, MODE_PRI_B: ref_d = master_ref;
         MODE_SEC_A, MODE_SEC_B: begin
            if (take_q) begin
               ref_d = master_ref;
            end else begin
               ref_d = own_b ? REF_BUS_A : REF_BUS_B;
            end
         end
         default: ref_d = REF_LOCAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ref_sel <= REF_LOCAL;
         ref_span <= '0;
         bus_clk_a_oe <= 1'b0;
         bus_clk_b_oe <= 1'b0;
         bus_clk_a_o <= 1'b0;
         bus_clk_b_o <= 1'b0;
         netref_oe <= 1'b0;
         netref_span <= '0;
         netref_freq <= '0;
         legacy_gen_sel <= '0;
      end else begin
         ref_sel <= ref_d;
         ref_span <= argbb_q;
         bus_clk_a_oe <= (is_pri || is_sec) && !own_b;
         bus_clk_b_oe <= (is_pri || is_sec) && own_b;
         bus_clk_a_o <= pll_clk_s;
         bus_clk_b_o <= pll_clk_s;
         netref_oe <= is_slave && arga_q[0];
         netref_span <= argbb_q;
         netref_freq <= sub_q == 3'h4 ? argc_q : '0;
         legacy_gen_sel <= (is_pri || is_sec) ? arga_q : '0;
      end
   end

   // ------------------------------------------------------------
   // Clock error bitmap
   // ------------------------------------------------------------
   logic [6:0] err_q;
   logic [6:0] err_set;
   logic [6:0] err_clr;
   logic watch_a;
   logic watch_b;
   logic in_fb;

   // A clock we drive ourselves is not judged by its own echo
   assign watch_a = (is_slave || is_sec) && !bus_clk_a_oe;
   assign watch_b = (is_slave || is_sec) && !bus_clk_b_oe;
   assign in_fb = fb_q || take_q || span_fb_q;

   always_comb begin
      err_set = '0;
      err_set[ERR_BUS_A] = watch_a && lost[MON_A];
      err_set[ERR_BUS_B] = watch_b && lost[MON_B];
      err_set[ERR_SC] = is_slave && sub_q inside {3'h2, 3'h3, 3'h4} &&
                        lost[MON_SC];
      err_set[ERR_MVIP] = is_slave && sub_q == 3'h5 && lost[MON_MVIP];
      err_set[ERR_PLL] = mode_q != MODE_NONE && !pll_locked;
      err_set[ERR_FAILSAFE] = in_fb;
   end

   assign err_clr = (wr_en && paddr == ADDR_ERR) ? pwdata[6:0] : '0;

   // Set wins over a simultaneous software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         err_q <= '0;
      end else begin
         err_q <= (err_q & ~err_clr) | err_set;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         err_report_valid <= 1'b0;
         err_report_data <= '0;
      end else begin
         err_report_valid <= |(err_set & ~err_q);
         err_report_data <= err_q | err_set | 7'h20;
      end
   end

   // ------------------------------------------------------------
   // Legacy stream mapping
   // ------------------------------------------------------------
   logic [31:0] smap_rd;
   always_comb begin
      smap_rd = '0;
      smap_rd[3:0] = smap_stream_q[4:1];
      smap_rd[4] = smap_stream_q[0];
      smap_rd[5] = smap_stream_q <= LEGACY_STREAM_MAX;
      smap_rd[6] = smap_ts_q <= TS_MAX_4M;
      smap_rd[SMAP_TS_LSB +: 7] = smap_ts_q;
      smap_rd[23:16] = {3'h0, smap_stream_q};
   end

   // ------------------------------------------------------------
   // APB read path: data captured in the setup cycle, no wait states
   // ------------------------------------------------------------
   logic [31:0] rd_d;
   logic rd_err;

   always_comb begin
      rd_d = '0;
      rd_err = 1'b0;
      case (paddr)
         ADDR_CLK_MODE: begin
            rd_d[MODE_LSB +: 3] = mode_q;
            rd_d[SUB_LSB +: 3] = sub_q;
            rd_d[ARGA_LSB +: 3] = arga_q;
            rd_d[ARGBB_LSB +: 8] = argbb_q;
            rd_d[ARGC_LSB +: 4] = argc_q;
         end
         ADDR_TERM: rd_d[1:0] = term_q;
         ADDR_ERR: rd_d[6:0] = err_q | 7'h20;
         ADDR_STATUS: begin
            rd_d[3:0] = ref_sel;
            rd_d[4] = fb_q;
            rd_d[5] = take_q;
            rd_d[6] = span_fb_q;
            rd_d[7] = cmd_err_q;
            rd_d[8] = pll_locked;
            rd_d[12:9] = lost;
         end
         ADDR_SPAN_TE: rd_d[7:0] = span_te_q;
         ADDR_STREAM_MAP: rd_d = smap_rd;
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? '0 : rd_d;
         pslverr <= rd_err;
      end
   end
   assign pready = 1'b1;
endmodule

/* File: tb/tdm_clk_monitor.sv */
// Checker for the bus clock controller ports
`timescale 1ns/10ps
module tdm_clk_monitor
   import tdm_clk_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   // Clock ownership and configuration
   input wire logic bus_clk_a_oe,
   input wire logic bus_clk_b_oe,
   input wire ref_t ref_sel,
   input wire logic netref_oe,
   input wire logic [2:0] legacy_gen_sel,
   input wire logic bus_term_en,
   input wire logic legacy_term_en,
   input wire logic err_report_valid,
   input wire logic [6:0] err_report_data
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [1:0] term_wd;
   logic wr_cmt;
   assign term_wd = pwdata[1:0];
   assign wr_cmt = psel && penable && pwrite;
   a_reset_quiet: assert property ($fell(reset) |-> !bus_clk_a_oe &&
      !bus_clk_b_oe && !netref_oe && ref_sel == REF_LOCAL)
      else $error("clock pins driven after reset");
   a_term_reset: assert property ($fell(reset) |-> !bus_term_en &&
      !legacy_term_en) else $error("termination on after reset");
   // The pins follow term_q one cycle after the write; the check waits two
   a_term_write: assert property (wr_cmt && paddr == ADDR_TERM |->
      ##2 {legacy_term_en, bus_term_en} == $past(term_wd, 2))
      else $error("termination pins differ from write");
   a_mode_none: assert property (wr_cmt && paddr == ADDR_CLK_MODE &&
      pwdata[2:0] == MODE_NONE |-> ##2 !bus_clk_a_oe && !bus_clk_b_oe
      && !netref_oe && legacy_gen_sel == 3'h0)
      else $error("mode zero still clocks the bus");
   a_unmapped_err: assert property (psel && !penable &&
      paddr > ADDR_STREAM_MAP |=> pslverr)
      else $error("unmapped access not refused");
   a_err_compat: assert property (err_report_valid |->
      err_report_data[ERR_COMPAT]) else $error("report bit five clear");
   a_one_driver: assert property (!(bus_clk_a_oe && bus_clk_b_oe))
      else $error("both bus clocks driven");
   a_no_self_lock: assert property (!(bus_clk_a_oe &&
      ref_sel == REF_BUS_A) && !(bus_clk_b_oe && ref_sel == REF_BUS_B))
      else $error("locked to own bus clock");
   a_netref_slave: assert property (netref_oe |-> !bus_clk_a_oe &&
      !bus_clk_b_oe && legacy_gen_sel == 3'h0)
      else $error("netref driven outside slave mode");
   a_legacy_master: assert property (legacy_gen_sel != 3'h0 |->
      bus_clk_a_oe || bus_clk_b_oe) else $error("legacy clocks as slave");
   c_report: cover property (err_report_valid);
   c_netref: cover property (netref_oe);
   c_holdover: cover property (bus_clk_b_oe && ref_sel == REF_HOLDOVER);
endmodule

bind tdm_clk_ctrl tdm_clk_monitor i_tdm_clk_monitor (
   .clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .bus_clk_a_oe(bus_clk_a_oe), .bus_clk_b_oe(bus_clk_b_oe),
   .ref_sel(ref_sel), .netref_oe(netref_oe),
   .legacy_gen_sel(legacy_gen_sel), .bus_term_en(bus_term_en),
   .legacy_term_en(legacy_term_en), .err_report_valid(err_report_valid),
   .err_report_data(err_report_data));

/* File: tb/bus_peer.sv */
// Model of the other boards on the backplane clock lines
`timescale 1ns/10ps
module bus_peer (
   // Faults commanded by the bench
   input wire logic run_a,
   input wire logic run_b,
   // Our drive enables
   input wire logic own_a_oe,
   input wire logic own_b_oe,
   // Clock lines
   output logic ct_a,
   output logic ct_b,
   output logic sc_clk,
   output logic mvip_clk
);
   logic lclk = 1'b0;
   always #24 lclk = ~lclk;
   // A failed master leaves its line to the pull-down, stuck low
   assign ct_a = (run_a && !own_a_oe) ? lclk : 1'b0;
   assign ct_b = (run_b && !own_b_oe) ? lclk : 1'b0;
   assign sc_clk = lclk;
   assign mvip_clk = ~lclk;
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the bus clock mode controller
`timescale 1ns/10ps
module tb;
   import tdm_clk_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pll_clk = 1'b0;
   logic run_a = 1'b1;
   logic run_b = 1'b1;
   logic lock = 1'b1;
   logic [7:0] los = 8'h00;
   logic [31:0] prdata, rdata, e;
   logic pready, pslverr, serr, a_o, a_oe, b_o, b_oe, pa, pb, sc, mv;
   logic nr_oe, bt, lt, ev;
   ref_t ref_sel;
   logic [7:0] ref_span, nr_span;
   logic [3:0] nr_freq;
   logic [2:0] lsel;
   logic [6:0] ed;
   logic [6:0] t;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   wire logic bus_a = a_oe ? a_o : pa;
   wire logic bus_b = b_oe ? b_o : pb;
   always #2 clk = ~clk;
   // Half period chosen so the local clock never moves on a rising clk edge
   always #12 pll_clk = ~pll_clk;
   bus_peer i_bus_peer (.run_a(run_a), .run_b(run_b), .own_a_oe(a_oe),
      .own_b_oe(b_oe), .ct_a(pa), .ct_b(pb), .sc_clk(sc), .mvip_clk(mv));
   tdm_clk_ctrl #(.NUM_SPANS(8)) i_tdm_clk_ctrl (.clk(clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_clk_a_i(bus_a), .bus_clk_a_o(a_o),
      .bus_clk_a_oe(a_oe), .bus_clk_b_i(bus_b), .bus_clk_b_o(b_o),
      .bus_clk_b_oe(b_oe), .legacy_sc_clk_i(sc), .legacy_mvip_clk_i(mv),
      .pll_clk_i(pll_clk), .pll_locked_i(lock), .ref_sel(ref_sel),
      .ref_span(ref_span), .netref_oe(nr_oe), .netref_span(nr_span),
      .netref_freq(nr_freq), .legacy_gen_sel(lsel), .span_los_i(los),
      .bus_term_en(bt), .legacy_term_en(lt), .err_report_valid(ev),
      .err_report_data(ed));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Zero wait states are not assumed: access holds until pready
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask
   task automatic st(input int b, input logic exp);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rdata[b]), 32'(exp));
   endtask
   task automatic setclk(input logic [2:0] m, input logic [2:0] s,
      input logic [2:0] a, input logic [7:0] bb, input logic [3:0] c);
      xfer(1'b1, ADDR_CLK_MODE, {4'h0, c, bb, 5'h0, a, 1'b0, s, 1'b0, m});
      repeat (3) @(posedge clk);
   endtask
   // Clock A stops, the first report pulse is checked, then A returns
   task automatic loss(input ref_t exp);
      int i;
      xfer(1'b1, ADDR_ERR, 32'h7f);
      run_a <= 1'b0;
      for (i = 0; i < 400 && ev !== 1'b1; i++) @(posedge clk);
      chk(32'({ed[ERR_COMPAT], ed[ERR_BUS_A]}), 32'h3);
      repeat (5) @(posedge clk);
      chk(ref_sel, exp);
      run_a <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_TERM, 32'h0);
      rd(ADDR_ERR, 32'h20);
      rd(ADDR_STATUS, 32'h100);
      chk({a_oe, b_oe, nr_oe}, 32'h0);
      xfer(1'b1, 8'h20, 32'h3);
      chk(serr, 32'h1);
      rd(8'h18, 32'h0);
      chk(serr, 32'h1);
      $display("done: reset and refusals");
      for (int k = 3; k >= 0; k--) begin
         xfer(1'b1, ADDR_TERM, 32'(k));
         rd(ADDR_TERM, 32'(k));
         chk({lt, bt}, 32'(k));
      end
      $display("done: termination");
      for (int s = 0; s < 32; s++) begin
         t = 7'h3e + 7'(s % 4);
         e = {11'h0, 5'(s), 1'b0, t, 1'b0, t <= 7'h3f, s <= 15,
              1'(s % 2), 4'(s / 2)};
         xfer(1'b1, ADDR_STREAM_MAP, {17'h0, t, 3'h0, 5'(s)});
         rd(ADDR_STREAM_MAP, e);
      end
      $display("done: stream map");
      for (int m = 0; m < 6; m++) begin
         setclk(3'(m), 3'h0, 3'h0, 8'h00, 4'h0);
         chk({a_oe, b_oe}, (m == 2 || m == 4) ? 2 :
             (m == 3 || m == 5) ? 1 : 0);
         st(7, 1'b0);
         if (m != 2 && m != 3) chk(ref_sel, m == 0 ? REF_LOCAL :
            m == 4 ? REF_BUS_B : REF_BUS_A);
      end
      setclk(3'h6, 3'h0, 3'h0, 8'h00, 4'h0);
      st(7, 1'b1);
      chk({a_oe, b_oe}, 32'h1);
      for (int s = 0; s < 8; s++) begin
         setclk(MODE_SLAVE, 3'(s), 3'h0, 8'h00, 4'h0);
         chk(ref_sel, s < 6 ? s + 1 : s - 5);
      end
      $display("done: modes");
      xfer(1'b1, ADDR_SPAN_TE, 32'h4);
      setclk(MODE_SLAVE, 3'h0, 3'h1, 8'h02, 4'h0);
      chk({nr_oe, nr_span}, 32'h102);
      setclk(MODE_SLAVE, 3'h0, 3'h0, 8'h02, 4'h0);
      chk(nr_oe, 32'h0);
      setclk(MODE_SLAVE, 3'h0, 3'h1, 8'h03, 4'h0);
      st(7, 1'b1);
      chk(nr_oe, 32'h0);
      $display("done: network reference");
      for (int k = 0; k < 6; k++) begin
         setclk(MODE_PRI_A, 3'h0, 3'(k), 8'h00, 4'h0);
         chk(lsel, 32'(k));
      end
      setclk(MODE_PRI_A, 3'h0, 3'h6, 8'h00, 4'h0);
      chk(lsel, 32'h5);
      setclk(MODE_PRI_B, 3'h1, 3'h0, 8'h01, 4'h0);
      chk({a_oe, lsel}, 32'hd);
      setclk(MODE_PRI_B, 3'h1, 3'h0, 8'h00, 4'h0);
      chk(ref_sel, REF_NETREF1);
      setclk(MODE_PRI_B, 3'h2, 3'h0, 8'h00, 4'h0);
      chk(ref_sel, REF_NETREF2);
      setclk(MODE_SEC_B, 3'h3, 3'h0, 8'h03, 4'h0);
      chk(ref_sel, REF_NETREF2);
      setclk(MODE_PRI_A, 3'h4, 3'h0, 8'h02, 4'h1);
      chk({ref_sel, ref_span, nr_freq}, {REF_SPAN, 12'h021});
      $display("done: master sources");
      setclk(MODE_SLAVE, 3'h6, 3'h0, 8'h00, 4'h0);
      loss(REF_BUS_B);
      rd(ADDR_ERR, 32'h61);
      setclk(MODE_SEC_B, 3'h0, 3'h0, 8'h00, 4'h0);
      loss(REF_HOLDOVER);
      st(5, 1'b1);
      chk(b_oe, 32'h1);
      st(10, 1'b0);
      setclk(MODE_SEC_B, 3'h1, 3'h0, 8'h00, 4'h0);
      loss(REF_NETREF1);
      lock <= 1'b0;
      repeat (4) @(posedge clk);
      rd(ADDR_ERR, 32'h71);
      $display("done: fallback and takeover");
      summarize();
   end
endmodule
